// ---- hw/lan_cfg_pkg.sv ----
package lan_cfg_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Configuration-space byte offsets
  localparam logic [7:0] ROM_BASE_OFS     = 8'h30;
  localparam logic [7:0] IRQ_WORD_OFS     = 8'h3C;
  localparam logic [7:0] LAN_CTRL_OFS     = 8'h40;
  localparam logic [7:0] STRAP_OFS        = 8'h44;
  localparam logic [7:0] PROM_BANG_OFS    = 8'h48;

  //////////////////////////////////////////////////////////////////////////////
  // Values after reset and fixed read values
  localparam logic [7:0] IRQ_LINE_RST     = 8'h00;
  localparam logic [7:0] IRQ_PIN_VAL      = 8'h01;
  localparam logic [7:0] MIN_GNT_RST      = 8'h01;
  localparam logic [7:0] MAX_LAT_RST      = 8'h00;
  localparam logic [1:0] TOPO_RST         = 2'h1;
  localparam logic [1:0] CLK_DIV_RST      = 2'h1;
  localparam logic [4:0] CTRL_FIXED_VAL   = 5'h09;
  localparam logic [3:0] PSEUDO_DMA_CODE  = 4'hF;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions in lan_subsystem_control
  localparam int CTRL_INT_LSB    = 4;
  localparam int CTRL_TOPO_LSB   = 8;
  localparam int CTRL_CONN_BIT   = 10;
  localparam int CTRL_FIXED_LSB  = 11;
  localparam int CTRL_SLEEP_BIT  = 16;
  localparam int CTRL_ROMPG_BIT  = 17;
  localparam int CTRL_DIV_LSB    = 19;
  localparam int CTRL_APAR_BIT   = 28;
  localparam int CTRL_DPAR_BIT   = 29;
  localparam int CTRL_RETRY_BIT  = 30;
  localparam int CTRL_SRST_BIT   = 31;

  // Field positions in serial_prom_bitbang
  localparam int PROM_CRC_BIT    = 8;
  localparam int PROM_ABSENT_BIT = 7;
  localparam int PROM_CLK_BIT    = 6;
  localparam int PROM_DRV_BIT    = 5;
  localparam int PROM_DATA_BIT   = 4;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS          = 5;
  localparam int SUBSYSTEM_RESET_OUT_LOW_NS          = 14000;
  localparam logic [11:0] SUBSYSTEM_RESET_OUT_CYC    = 12'((SUBSYSTEM_RESET_OUT_LOW_NS + CLK_PERIOD_NS - 1)
                                              / CLK_PERIOD_NS);
  localparam logic [1:0] SRST_BIT_CYC   = 2'd3;  // Bit stands four cycles
  localparam logic [1:0] STRAP_SETTLE   = 2'd2;  // Synchroniser depth

endpackage : lan_cfg_pkg

// ---- hw/pin_sync2.sv ----
`timescale 1ns/10ps
module pin_sync2 #(
  parameter int W = 1
) (
  input  logic         i_clk,
  input  logic         i_sys_rst,
  input  logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;

  // Two-stage capture; first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : pin_sync2

// ---- hw/proc_clk_div.sv ----
`timescale 1ns/10ps
module proc_clk_div (
  input  logic       i_clk,
  input  logic       i_sys_rst,
  input  logic [1:0] i_div_code,
  input  logic       i_sleep,
  output logic       o_clk_out
);

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] last_w;
  logic [1:0] hi_len_w;
  logic       out_d;

  // Period is code+1 cycles, two for code 0; high phase is the longer half
  assign last_w   = i_div_code;
  assign hi_len_w = 2'((3'(i_div_code) + 3'd2) >> 1);
  assign cnt_d    = (cnt_q >= last_w) ? 2'd0 : cnt_q + 2'd1;
  // Divide-by-one cannot leave a flop; it toggles each edge instead
  assign out_d    = i_sleep ? 1'b1 :
                    (i_div_code == 2'd0) ? ~o_clk_out : (cnt_d < hi_len_w);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q     <= 2'd0;
      o_clk_out <= 1'b0;
    end else begin
      cnt_q     <= i_sleep ? 2'd0 : cnt_d;
      o_clk_out <= out_d;
    end
  end

endmodule : proc_clk_div

// ---- hw/lan_cfg_regs.sv ----
`timescale 1ns/10ps
// Contract
// - ROM base keeps bits 31:16 and bit 0; bits 15:1 read zero.
// - Interrupt line is 8-bit read/write, reset zero, low nibble forwarded.
// - Interrupt pin reads constant one.
// - Minimum grant loaded from prom download, one when prom absent.
// - Maximum latency loaded from prom download, zero when prom absent.
// - Control bits 3:0 are channel, mirrored; all-ones means pseudo-DMA.
// - Control bits 7:4 read-only echo of interrupt line low nibble.
// - Control bits 9:8 topology code, reset 01, mirrored to compat.
// - Control bit 10 drives connector pin, reset zero.
// - Sleep bit 16 holds processor clock high; clearing resumes clocking.
// - Bit 17 selects paged 14-bit ROM addressing; reset full 16-bit.
// - Bits 20:19 divide processor clock by code+1 (2..4), code 0 also by two; reset divide two.
// - Bit 28 sets on target address parity error; reset zero.
// - Bit 29 sets on master data parity error; reset zero.
// - Bit 30 sets on master retry limit exceeded; reset zero.
// - Writing bit 31 drives subsystem reset low at least 14 us.
// - Software reset bit clears itself four clocks after set.
// - Control bits 15:11 read 0x09; bit 18 reads zero.
// - Strap pins captured into board register at reset release; upper zero.
// - Prom CRC failure sets crc flag and absent flag together.
// - Absent flag sets on data pin low at reset or checksum failure.
// - Bit 6 drives prom clock; bit 5 with bit 4 zero drives the data pin low; bit 4 one releases it.
// - Bus-master enable falling with auto control clear triggers software reset.
module lan_cfg_regs (
  input  logic        i_clk,
  input  logic        i_sys_rst,
  input  logic        i_cfg_wr,
  input  logic        i_cfg_rd,
  input  logic [7:0]  i_cfg_addr,
  input  logic [3:0]  i_cfg_be,
  input  logic [31:0] i_cfg_wdata,
  output logic [31:0] o_cfg_rdata,
  output logic        o_cfg_ack,
  input  logic        i_bus_master_en,
  input  logic        i_auto_subsystem_reset_out_off,
  input  logic        i_addr_parity_err,
  input  logic        i_master_data_parity_err,
  input  logic        i_retry_expired,
  input  logic        i_prom_load_done,
  input  logic        i_prom_crc_fail,
  input  logic [7:0]  i_prom_min_grant,
  input  logic [7:0]  i_prom_max_latency,
  input  logic [7:0]  i_rom_addr_straps,
  input  logic        i_prom_data_pin,
  output logic        o_prom_data_pin,
  output logic        o_prom_data_pin_oe,
  output logic        o_prom_clock_pin,
  output logic        o_processor_clock_out,
  output logic        o_subsystem_reset_out_n,
  output logic        o_connector_type_pin,
  output logic        o_rom_page_mode,
  output logic        o_pseudo_dma,
  output logic [15:0] o_compat_cfg
);

  //////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0] rom_base_hi_q;
  logic        rom_dec_en_q;
  logic [7:0]  irq_line_q;
  logic [7:0]  min_grant_q;
  logic [7:0]  max_latency_q;
  logic [3:0]  dma_chan_q;
  logic [1:0]  topo_q;
  logic        conn_q;
  logic        sleep_q;
  logic        rom_page_q;
  logic [1:0]  clk_div_q;
  logic        addr_par_q;
  logic        data_par_q;
  logic        retry_q;
  logic        srst_bit_q;
  logic [1:0]  srst_bit_cnt_q;
  logic [11:0] srst_cnt_q;
  logic [7:0]  strap_q;
  logic        strap_done_q;
  logic [1:0]  strap_cnt_q;
  logic        prom_crc_q;
  logic        prom_absent_q;
  logic        prom_clk_q;
  logic        prom_drv_q;
  logic        prom_data_q;
  logic        bm_en_q;
  logic [11:0] low_len_q;
  logic [7:0]  straps_sync;
  logic        prom_pin_sync;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and write strobes
  wire hit_rom   = (i_cfg_addr == lan_cfg_pkg::ROM_BASE_OFS);
  wire hit_irq   = (i_cfg_addr == lan_cfg_pkg::IRQ_WORD_OFS);
  wire hit_ctrl  = (i_cfg_addr == lan_cfg_pkg::LAN_CTRL_OFS);
  wire hit_strap = (i_cfg_addr == lan_cfg_pkg::STRAP_OFS);
  wire hit_prom  = (i_cfg_addr == lan_cfg_pkg::PROM_BANG_OFS);
  wire wr_rom    = i_cfg_wr & hit_rom;
  wire wr_irq    = i_cfg_wr & hit_irq;
  wire wr_ctrl   = i_cfg_wr & hit_ctrl;
  wire wr_prom   = i_cfg_wr & hit_prom;

  // Software reset request: bit 31 write, or bus-master enable falling while the auto-reset-off input is clear
  wire bm_fall   = bm_en_q & ~i_bus_master_en & ~i_auto_subsystem_reset_out_off;
  wire srst_wr   = wr_ctrl & i_cfg_be[3] & i_cfg_wdata[lan_cfg_pkg::CTRL_SRST_BIT];
  wire srst_req  = srst_wr | bm_fall;
  wire strap_cap = ~strap_done_q & (strap_cnt_q == lan_cfg_pkg::STRAP_SETTLE);

  // Data bit reads the pin unless the drive bit is set; then it reads the written data bit
  wire prom_data_rd = prom_drv_q ? prom_data_q : prom_pin_sync;

  //////////////////////////////////////////////////////////////////////////////
  // Read-back images
  wire [31:0] rom_img  = {rom_base_hi_q, 15'h0000, rom_dec_en_q};
  wire [31:0] irq_img  = {max_latency_q, min_grant_q,
                          lan_cfg_pkg::IRQ_PIN_VAL, irq_line_q};
  wire [31:0] ctrl_img = {srst_bit_q, retry_q, data_par_q, addr_par_q,
                          7'h00, clk_div_q, 1'b0, rom_page_q, sleep_q,
                          lan_cfg_pkg::CTRL_FIXED_VAL, conn_q, topo_q,
                          irq_line_q[3:0], dma_chan_q};
  wire [31:0] strp_img = {24'h000000, strap_q};
  wire [31:0] prom_img = {23'h000000, prom_crc_q, prom_absent_q, prom_clk_q,
                          prom_drv_q, prom_data_rd, 4'h0};
  wire [31:0] rd_mux   = hit_rom   ? rom_img  :
                         hit_irq   ? irq_img  :
                         hit_ctrl  ? ctrl_img :
                         hit_strap ? strp_img :
                         hit_prom  ? prom_img : 32'h00000000;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pin_sync2 #(.W(8)) u_strap_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_rom_addr_straps),
    .o_sync    (straps_sync)
  );

  pin_sync2 #(.W(1)) u_prom_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   (i_prom_data_pin),
    .o_sync    (prom_pin_sync)
  );

  // Processor clock generator
  proc_clk_div u_proc_clk (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_div_code (clk_div_q),
    .i_sleep    (sleep_q),
    .o_clk_out  (o_processor_clock_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // ROM base and interrupt word
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rom_base_hi_q <= 16'h0000;
      rom_dec_en_q  <= 1'b0;
      irq_line_q    <= lan_cfg_pkg::IRQ_LINE_RST;
    end else begin
      if (wr_rom & i_cfg_be[0]) rom_dec_en_q <= i_cfg_wdata[0];
      if (wr_rom & i_cfg_be[2]) rom_base_hi_q[7:0] <= i_cfg_wdata[23:16];
      if (wr_rom & i_cfg_be[3]) rom_base_hi_q[15:8] <= i_cfg_wdata[31:24];
      if (wr_irq & i_cfg_be[0]) irq_line_q <= i_cfg_wdata[7:0];
    end
  end

  // Grant and latency from the prom download; defaults stand otherwise
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      min_grant_q   <= lan_cfg_pkg::MIN_GNT_RST;
      max_latency_q <= lan_cfg_pkg::MAX_LAT_RST;
    end else if (i_prom_load_done & ~i_prom_crc_fail & ~prom_absent_q) begin
      min_grant_q   <= i_prom_min_grant;
      max_latency_q <= i_prom_max_latency;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writable control fields
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dma_chan_q <= 4'h0;
      topo_q     <= lan_cfg_pkg::TOPO_RST;
      conn_q     <= 1'b0;
      sleep_q    <= 1'b0;
      rom_page_q <= 1'b0;
      clk_div_q  <= lan_cfg_pkg::CLK_DIV_RST;
    end else begin
      if (wr_ctrl & i_cfg_be[0]) dma_chan_q <= i_cfg_wdata[3:0];
      if (wr_ctrl & i_cfg_be[1]) begin
        topo_q <= i_cfg_wdata[lan_cfg_pkg::CTRL_TOPO_LSB +: 2];
        conn_q <= i_cfg_wdata[lan_cfg_pkg::CTRL_CONN_BIT];
      end
      if (wr_ctrl & i_cfg_be[2]) begin
        sleep_q    <= i_cfg_wdata[lan_cfg_pkg::CTRL_SLEEP_BIT];
        rom_page_q <= i_cfg_wdata[lan_cfg_pkg::CTRL_ROMPG_BIT];
        clk_div_q  <= i_cfg_wdata[lan_cfg_pkg::CTRL_DIV_LSB +: 2];
      end
    end
  end

  // Error flags are sticky; nothing but reset clears them
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_par_q <= 1'b0;
      data_par_q <= 1'b0;
      retry_q    <= 1'b0;
    end else begin
      addr_par_q <= addr_par_q | i_addr_parity_err;
      data_par_q <= data_par_q | i_master_data_parity_err;
      retry_q    <= retry_q | i_retry_expired;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software reset bit and subsystem reset pulse
  // A request while the pulse runs is absorbed, never shortened
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bm_en_q        <= 1'b0;
      srst_bit_q     <= 1'b0;
      srst_bit_cnt_q <= 2'd0;
      srst_cnt_q     <= 12'd0;
    end else begin
      bm_en_q <= i_bus_master_en;
      if (srst_req & ~srst_bit_q) begin
        srst_bit_q     <= 1'b1;
        srst_bit_cnt_q <= 2'd0;
      end else if (srst_bit_q) begin
        srst_bit_cnt_q <= srst_bit_cnt_q + 2'd1;
        if (srst_bit_cnt_q == lan_cfg_pkg::SRST_BIT_CYC) srst_bit_q <= 1'b0;
      end
      if (srst_req & (srst_cnt_q == 12'd0)) begin
        srst_cnt_q <= lan_cfg_pkg::SUBSYSTEM_RESET_OUT_CYC;
      end else if (srst_cnt_q != 12'd0) begin
        srst_cnt_q <= srst_cnt_q - 12'd1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap and prom-presence capture after reset release
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strap_q       <= 8'h00;
      strap_done_q  <= 1'b0;
      strap_cnt_q   <= 2'd0;
      prom_absent_q <= 1'b0;
      prom_crc_q    <= 1'b0;
    end else begin
      if (~strap_done_q) strap_cnt_q <= strap_cnt_q + 2'd1;
      if (strap_cap) begin
        strap_q      <= straps_sync;
        strap_done_q <= 1'b1;
      end
      if (strap_cap & ~prom_pin_sync) prom_absent_q <= 1'b1;
      if (i_prom_crc_fail) begin
        prom_crc_q    <= 1'b1;
        prom_absent_q <= 1'b1;
      end
    end
  end

  // Bit-bang port
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prom_clk_q  <= 1'b0;
      prom_drv_q  <= 1'b0;
      prom_data_q <= 1'b0;
    end else if (wr_prom & i_cfg_be[0]) begin
      prom_clk_q  <= i_cfg_wdata[lan_cfg_pkg::PROM_CLK_BIT];
      prom_drv_q  <= i_cfg_wdata[lan_cfg_pkg::PROM_DRV_BIT];
      prom_data_q <= i_cfg_wdata[lan_cfg_pkg::PROM_DATA_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs and bus answer
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cfg_rdata             <= 32'h00000000;
      o_cfg_ack               <= 1'b0;
      o_prom_data_pin         <= 1'b0;
      o_prom_data_pin_oe      <= 1'b0;
      o_prom_clock_pin        <= 1'b0;
      o_subsystem_reset_out_n <= 1'b1;
      o_connector_type_pin    <= 1'b0;
      o_rom_page_mode         <= 1'b0;
      o_pseudo_dma            <= 1'b0;
      o_compat_cfg            <= 16'h0000;
    end else begin
      o_cfg_rdata             <= i_cfg_rd ? rd_mux : 32'h00000000;
      o_cfg_ack               <= i_cfg_rd | i_cfg_wr;
      o_prom_data_pin         <= prom_data_q;
      o_prom_data_pin_oe      <= prom_drv_q & ~prom_data_q;
      o_prom_clock_pin        <= prom_clk_q;
      o_subsystem_reset_out_n <= (srst_cnt_q == 12'd0);
      o_connector_type_pin    <= conn_q;
      o_rom_page_mode         <= rom_page_q;
      o_pseudo_dma            <= (dma_chan_q == lan_cfg_pkg::PSEUDO_DMA_CODE);
      o_compat_cfg            <= {4'h9, 1'b0, conn_q, topo_q,
                                  irq_line_q[3:0], dma_chan_q};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  // Helper: cycles the subsystem reset has stood low
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) low_len_q <= 12'd0;
    else if (o_subsystem_reset_out_n) low_len_q <= 12'd0;
    else if (low_len_q != 12'hFFF) low_len_q <= low_len_q + 12'd1;
  end

  sequence srst_set_s;
    $rose(srst_bit_q);
  endsequence

  sequence srst_hold_s;
    srst_bit_q [*4] ##1 !srst_bit_q;
  endsequence

  rom_low_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_cfg_rd && hit_rom) |=> o_cfg_rdata[15:1] == 15'h0000)
    else $error("rom base low bits not zero");

  irq_pin_one_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_cfg_rd && hit_irq) |=> o_cfg_rdata[15:8] == 8'h01)
    else $error("interrupt pin not one");

  int_echo_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_cfg_rd && hit_ctrl) |=> o_cfg_rdata[7:4] == $past(irq_line_q[3:0])
      && o_cfg_rdata[15:11] == 5'h09 && !o_cfg_rdata[18])
    else $error("control echo or fixed bits wrong");

  sleep_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    sleep_q |=> o_processor_clock_out)
    else $error("processor clock not held high in sleep");

  srst_self_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    srst_set_s |-> srst_hold_s)
    else $error("software reset bit did not clear after four cycles");

  srst_pulse_len_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_subsystem_reset_out_n) |-> low_len_q >= 12'(lan_cfg_pkg::SUBSYSTEM_RESET_OUT_CYC))
    else $error("subsystem reset pulse too short");

  srst_start_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    srst_set_s |-> ##1 !o_subsystem_reset_out_n)
    else $error("subsystem reset not driven low");

  flag_sticky_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_addr_parity_err || addr_par_q) |=> addr_par_q)
    else $error("address parity flag lost");

  crc_absent_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_prom_crc_fail |=> prom_crc_q && prom_absent_q)
    else $error("crc fail did not set both flags");

  conn_pin_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ##1 o_connector_type_pin == $past(conn_q))
    else $error("connector pin does not follow bit");

  bm_reset_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (bm_fall && !srst_bit_q) |=> srst_bit_q)
    else $error("bus-master fall did not start reset");

endmodule : lan_cfg_regs

// ---- sim/cfg_host_model.sv ----
`timescale 1ns/10ps
// Host bridge side: one config cycle at a time, driven on falling edges
module cfg_host_model (
  input  wire logic        i_clk,
  input  wire logic        i_cfg_ack,
  input  wire logic [31:0] i_cfg_rdata,
  output logic             o_cfg_wr,
  output logic             o_cfg_rd,
  output logic [7:0]       o_cfg_addr,
  output logic [3:0]       o_cfg_be,
  output logic [31:0]      o_cfg_wdata
);
  initial begin
    o_cfg_wr = 1'b0;
    o_cfg_rd = 1'b0;
    o_cfg_addr = 8'h00;
    o_cfg_be = 4'h0;
    o_cfg_wdata = 32'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Strobe for one edge; released lines show inverted junk, not stale values
  task automatic xfer(input bit w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] q, output bit ok);
    ok = 1'b0;
    q = 32'h0;
    @(negedge i_clk);
    o_cfg_wr = w;
    o_cfg_rd = !w;
    o_cfg_addr = a;
    o_cfg_be = b;
    o_cfg_wdata = d;
    // Strobe is a one-cycle pulse; ack and data stand the cycle after it
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge i_clk);
      o_cfg_wr = 1'b0;
      o_cfg_rd = 1'b0;
      if (i_cfg_ack === 1'b1) begin
        ok = 1'b1;
        q = i_cfg_rdata;
      end
    end
    o_cfg_addr = ~a;
    o_cfg_be = ~b;
    o_cfg_wdata = ~d;
  endtask : xfer
endmodule : cfg_host_model

// ---- sim/tb_pci_lan_bridge_config_regs.sv ----
`timescale 1ns/10ps
// Self-checking bench for the configuration register bank
module tb_pci_lan_bridge_config_regs;
  logic        clk, rst, wr, rd, ack, bme, aoff, apar, dpar, retry, load, crc;
  logic        pout, poe, prom_clock_level, pclk, srst_n, conn, page, pdma, pin_low;
  logic [7:0]  addr, straps, ming, maxl;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, got;
  logic [15:0] compat;
  int          num_errors, check_count, n;
  bit          ok;
  // Open-drain line with pull-up: low while the block sinks it or a pulldown sits
  wire         pinw = !poe && !pin_low;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  lan_cfg_regs DUT (.i_clk(clk), .i_sys_rst(rst), .i_cfg_wr(wr), .i_cfg_rd(rd),
    .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
    .o_cfg_ack(ack), .i_bus_master_en(bme), .i_auto_subsystem_reset_out_off(aoff),
    .i_addr_parity_err(apar), .i_master_data_parity_err(dpar), .i_retry_expired(retry),
    .i_prom_load_done(load), .i_prom_crc_fail(crc), .i_prom_min_grant(ming),
    .i_prom_max_latency(maxl), .i_rom_addr_straps(straps), .i_prom_data_pin(pinw),
    .o_prom_data_pin(pout), .o_prom_data_pin_oe(poe), .o_prom_clock_pin(prom_clock_level),
    .o_processor_clock_out(pclk), .o_subsystem_reset_out_n(srst_n),
    .o_connector_type_pin(conn), .o_rom_page_mode(page), .o_pseudo_dma(pdma),
    .o_compat_cfg(compat));

  cfg_host_model host (.i_clk(clk), .i_cfg_ack(ack), .i_cfg_rdata(rdata), .o_cfg_wr(wr),
    .o_cfg_rd(rd), .o_cfg_addr(addr), .o_cfg_be(be), .o_cfg_wdata(wdata));

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  // A missing ack ends the run at once
  task automatic rw(input bit w, input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    host.xfer(w, a, b, d, got, ok);
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED %0t no ack", $time);
      give_verdict();
    end
  endtask : rw

  // Counts falling edges the subsystem reset stays low
  task automatic low_len;
    n = 0;
    for (int i = 0; i < 8 && srst_n !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 3000 && srst_n === 1'b0; i++) begin
      @(negedge clk);
      n++;
    end
  endtask : low_len

  // Processor clock period in PCI cycles, rise to rise
  task automatic period;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      for (int i = 0; i < 20 && pclk !== 1'b0; i++) begin @(negedge clk); n++; end
      for (int i = 0; i < 20 && pclk !== 1'b1; i++) begin @(negedge clk); n++; end
    end
  endtask : period

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    rw(0, 8'h3C, 4'h0, 0); chk(got, 32'h0001_0100, "irq word");
    rw(0, 8'h40, 4'h0, 0); chk(got, 32'h0008_4900, "ctrl");
    rw(0, 8'h30, 4'h0, 0); chk(got, 0, "rom base");
    rw(0, 8'h44, 4'h0, 0); chk(got, 32'hA5, "straps");
    rw(0, 8'h48, 4'h0, 0); chk(got, 32'h10, "prom");
    rw(0, 8'h50, 4'h0, 0); chk(got, 0, "unmapped");
    chk({pdma, conn, page, srst_n}, 4'b0001, "pins");
    period(); chk(n, 2, "reset divide");
  endtask : t_reset_vals

  task automatic t_rom_irq;
    rw(1, 8'h30, 4'hF, 32'hFFFF_FFFF);
    rw(0, 8'h30, 4'h0, 0); chk(got, 32'hFFFF_0001, "rom base");
    rw(1, 8'h3C, 4'hF, 32'hFFFF_FFA7);
    rw(0, 8'h3C, 4'h0, 0); chk(got, 32'h0001_01A7, "irq word");
    chk(compat[7:4], 4'h7, "compat irq");
  endtask : t_rom_irq

  task automatic t_ctrl;
    rw(1, 8'h40, 4'h7, 32'h001E_060F);
    rw(0, 8'h40, 4'h0, 0); chk(got, 32'h001A_4E7F, "ctrl");
    chk({pdma, conn, page}, 3'b111, "pins");
    chk(compat, 16'h967F, "compat");
    for (int c = 0; c < 4; c++) begin
      rw(1, 8'h40, 4'h3, 32'(c) << 8);
      @(negedge clk);
      chk({compat[9:8], pdma}, {2'(c), 1'b0}, "topology");
    end
  endtask : t_ctrl

  task automatic t_clk;
    for (int c = 1; c < 4; c++) begin
      rw(1, 8'h40, 4'h4, 32'(c) << 19);
      period(); chk(n, c + 1, "divide");
    end
    rw(1, 8'h40, 4'h4, 32'h0001_0000);
    repeat (10) begin @(negedge clk); chk(pclk, 1, "sleep"); end
    rw(1, 8'h40, 4'h4, 32'h0008_0000);
    period(); chk(n, 2, "wake");
  endtask : t_clk

  task automatic t_flags;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      {retry, dpar, apar} = 3'b001 << i;
      @(negedge clk);
      {retry, dpar, apar} = 3'b000;
      rw(0, 8'h40, 4'h0, 0); chk(got[30:28], (2 << i) - 1, "flags");
    end
  endtask : t_flags

  task automatic t_subsystem_reset_out;
    rw(1, 8'h40, 4'h8, 32'h8000_0000);
    low_len(); chk(n >= 2800 && n < 2810, 1, "reset width");
    rw(0, 8'h40, 4'h0, 0); chk(got[31:28], 4'h7, "bit31 clear");
    rw(1, 8'h40, 4'h8, 32'h8000_0000);
    rw(0, 8'h40, 4'h0, 0); chk(got[31], 1, "bit31 set");
    low_len();
    bme = 1'b1;
    repeat (3) @(negedge clk);
    bme = 1'b0;
    low_len(); chk(n >= 2800 && n < 2810, 1, "master off reset");
    aoff = 1'b1;
    bme = 1'b1;
    repeat (3) @(negedge clk);
    bme = 1'b0;
    low_len(); chk(n, 0, "auto reset off");
  endtask : t_subsystem_reset_out

  task automatic t_prom;
    rw(1, 8'h48, 4'h1, 32'h60);
    rw(0, 8'h48, 4'h0, 0); chk({got[6:4], prom_clock_level, poe, pout}, 6'b110110, "drive low");
    rw(1, 8'h48, 4'h1, 32'h70);
    rw(0, 8'h48, 4'h0, 0); chk({got[6:4], prom_clock_level, poe, pout}, 6'b111101, "drive high");
    rw(1, 8'h48, 4'h1, 32'h00);
    repeat (4) @(negedge clk);
    rw(0, 8'h48, 4'h0, 0); chk({got[6:4], prom_clock_level, poe, pout}, 6'b001000, "float");
    ming = 8'h20;
    maxl = 8'h40;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    rw(0, 8'h3C, 4'h0, 0); chk(got, 32'h4020_01A7, "download");
    crc = 1'b1;
    @(negedge clk);
    crc = 1'b0;
    rw(0, 8'h48, 4'h0, 0); chk(got[8:7], 2'b11, "crc");
  endtask : t_prom

  // Second reset in mid-run with the prom data pin pulled low
  task automatic t_mid_reset;
    @(negedge clk);
    rst = 1'b1;
    pin_low = 1'b1;
    straps = 8'h5A;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    pin_low = 1'b0;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    rw(0, 8'h48, 4'h0, 0); chk(got[8:7], 2'b01, "absent");
    rw(0, 8'h44, 4'h0, 0); chk(got, 32'h5A, "straps again");
    rw(0, 8'h3C, 4'h0, 0); chk(got, 32'h0001_0100, "no prom");
  endtask : t_mid_reset

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    check_count = 0;
    {rst, bme, aoff, apar, dpar, retry, load, crc} = 8'h80;
    straps = 8'hA5;
    pin_low = 1'b0;
    ming = 8'h00;
    maxl = 8'h00;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset_vals();
    t_rom_irq();
    t_ctrl();
    t_clk();
    t_flags();
    t_subsystem_reset_out();
    t_prom();
    t_mid_reset();
    give_verdict();
  end
endmodule : tb_pci_lan_bridge_config_regs
